// ---- adcc_params.svh ----
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
// Register byte offsets
`define ADCC_OFF_CHSEL 8'h00
`define ADCC_OFF_CSA 8'h04
`define ADCC_OFF_CSB 8'h08
`define ADCC_OFF_RESL 8'h0C
`define ADCC_OFF_RESH 8'h10
// channel_select_register fields
`define ADCC_CH_REF_LSB 6
`define ADCC_CH_LADJ 5
`define ADCC_CH_MUX_LSB 0
// control_status_a fields
`define ADCC_A_EN 7
`define ADCC_A_SC 6
`define ADCC_A_ATE 5
`define ADCC_A_IF 4
`define ADCC_A_IE 3
`define ADCC_A_PS_LSB 0
// control_status_b fields
`define ADCC_B_TS_LSB 0
// Reset values
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_RES 10'h000
// Conversion lengths in converter clocks
`define ADCC_CYC_NORMAL 5'h0D
`define ADCC_CYC_FIRST 5'h19
// Number of external trigger sources
`define ADCC_TRIG_N 7
// AXI responses
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`endif

// ---- adcc_pkg.sv ----
`include "adcc_params.svh"
package adcc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} adcc_conv_st_t;
  // Signals towards the analog converter
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [4:0] mux_sel;
    logic conv_on;
    logic sample;
  } adcc_analog_t;
  // Prescaler state
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } adcc_psc_t;
  // Trigger synchroniser state
  typedef struct packed {
    logic [`ADCC_TRIG_N-1:0] s1;
    logic [`ADCC_TRIG_N-1:0] s2;
  } adcc_sync_t;
  // Main control state
  typedef struct packed {
    logic [1:0] ref_p;
    logic ladj;
    logic [4:0] mux_p;
    logic [1:0] ref_a;
    logic [4:0] mux_a;
    logic en;
    logic ate;
    logic flag;
    logic ie;
    logic [2:0] ps;
    logic [2:0] ts;
    adcc_conv_st_t st;
    logic [4:0] cnt;
    logic first;
    logic lock;
    logic [9:0] res;
    logic trig_q;
    logic sample;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_stb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } adcc_state_t;
endpackage

// ---- adcc_prescaler.sv ----
`timescale 1ns/1ps
module adcc_prescaler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] ps_sel,
  // Converter clock strobe
  output logic tick
);
  import adcc_pkg::*;
  adcc_psc_t s_r;
  adcc_psc_t s_nxt;
  logic [2:0] shift;
  logic [6:0] mask;

  // Divide by two for codes 0 and 1, else by 2^code
  assign shift = (ps_sel == 3'h0) ? 3'h1 : ps_sel;
  assign mask = 7'((8'h01 << shift) - 8'h01);

  // Counter held clear while stopped or restarted
  always_comb begin
    s_nxt = s_r;
    if (!run || restart) begin
      s_nxt.cnt = 7'h00;
      s_nxt.tick = 1'b0;
    end else begin
      s_nxt.cnt = 7'(s_r.cnt + 7'h01);
      s_nxt.tick = ((s_r.cnt & mask) == mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// ---- adcc_trig_sync.sv ----
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_trig_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw and synchronised triggers
  input wire logic [`ADCC_TRIG_N-1:0] trig_raw,
  output logic [`ADCC_TRIG_N-1:0] trig_sync
);
  import adcc_pkg::*;
  adcc_sync_t s_r;
  adcc_sync_t s_nxt;

  // Two flops per input, first read only by second
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = trig_raw;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trig_sync = s_r.s2;
endmodule

// ---- adcc_top.sv ----
// Contract
// RQ1: Reference and channel reach the converter only while the converter is enabled.
// RQ2: Result is right aligned by default, left aligned with left_adjust_select.
// RQ3: Software reads low byte then high byte for a consistent full result.
// RQ4: Reading the low byte blocks result writes until the high byte is read; a completion in the cycle of the low byte read still writes.
// RQ5: A conversion completing while blocked leaves both bytes and is lost.
// RQ6: Reading the high byte unblocks result writes.
// RQ7: Every completion sets the done flag, even when the result was lost.
// RQ8: Writing one to start_conversion_bit begins a single conversion.
// RQ9: start_conversion_bit stays high during conversion, cleared by hardware at end.
// RQ10: A channel change mid conversion takes effect only after it completes.
// RQ11: Auto triggering runs when enabled, from the selected trigger source.
// RQ12: Rising trigger edge resets the prescaler and starts a conversion.
// RQ13: Only edges trigger; a trigger still high at completion does nothing.
// RQ14: Trigger edges during a conversion are ignored, never queued.
// RQ15: Source flags used as triggers are set regardless of interrupt enables.
// RQ16: Software clears the trigger source flag before its next event.
// RQ17: Done flag as trigger restarts conversions immediately, free running.
// RQ18: Software starts the first free running conversion via start_conversion_bit.
// RQ19: Free running continues whether or not the done flag is cleared.
// RQ20: With auto triggering on, a start write still starts one conversion.
// RQ21: start_conversion_bit reads one during any conversion, however started.
// RQ22: Input mux field selects 8 single ended channels plus differential pairs.
// RQ23: Normal conversion takes 13 converter clocks, first after enable 25.
// RQ24: At completion result and flag update; single mode clears start together.
// RQ25: Prescaler runs while enabled and is held reset while disabled.
// RQ26: Software start begins at the next prescaled converter clock edge.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter side
  output adcc_pkg::adcc_analog_t analog_o,
  input wire logic [9:0] conv_data_i,
  // Trigger source flags from other blocks
  input wire logic [`ADCC_TRIG_N-1:0] trig_flag_i,
  // Conversion complete request
  output logic conv_irq_o
);
  import adcc_pkg::*;

  adcc_state_t s_r;
  adcc_state_t s_nxt;
  logic tick;
  logic [`ADCC_TRIG_N-1:0] trig_s;
  logic trig_sig;
  logic trig_edge;
  logic trig_start;
  logic free_run;
  logic [4:0] conv_len;
  logic cmpl;
  logic wr_go;
  logic wr_ok;
  logic wr_ch;
  logic wr_a;
  logic wr_b;
  logic sc_wr;
  logic rd_go;
  logic rd_lo;
  logic rd_hi;
  logic [7:0] res_lo;
  logic [7:0] res_hi;

  // Trigger flags come from other logic domains
  adcc_trig_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig_raw(trig_flag_i),
    .trig_sync(trig_s)
  );

  // Converter clock, held clear while disabled
  adcc_prescaler u_psc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_r.en), // RQ25
    .restart(trig_start), // RQ12
    .ps_sel(s_r.ps),
    .tick(tick)
  );

  // Bus handshakes
  assign awready = !s_r.aw_have && !s_r.bvalid;
  assign wready = !s_r.w_have && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
  assign rd_go = arvalid && arready;

  // Write decode, low byte lane only
  assign wr_ok = wr_go && s_r.w_stb;
  assign wr_ch = wr_ok && (s_r.aw_addr == `ADCC_OFF_CHSEL);
  assign wr_a = wr_ok && (s_r.aw_addr == `ADCC_OFF_CSA);
  assign wr_b = wr_ok && (s_r.aw_addr == `ADCC_OFF_CSB);
  assign sc_wr = wr_a && s_r.w_data[`ADCC_A_SC] && s_r.w_data[`ADCC_A_EN]; // RQ8 RQ20

  // Read decode of the result bytes
  assign rd_lo = rd_go && (araddr[7:0] == `ADCC_OFF_RESL);
  assign rd_hi = rd_go && (araddr[7:0] == `ADCC_OFF_RESH);

  // Result alignment
  assign res_lo = s_r.ladj ? {s_r.res[1:0], 6'h00} : s_r.res[7:0]; // RQ2
  assign res_hi = s_r.ladj ? s_r.res[9:2] : {6'h00, s_r.res[9:8]}; // RQ2

  // Trigger selection and edge detect
  assign free_run = s_r.ate && (s_r.ts == 3'h0); // RQ17
  always_comb begin
    if (s_r.ts == 3'h0) begin
      trig_sig = s_r.flag;
    end else begin
      trig_sig = trig_s[3'(s_r.ts - 3'h1)]; // RQ11 RQ15
    end
  end
  assign trig_edge = s_r.ate && trig_sig && !s_r.trig_q; // RQ13
  assign trig_start = trig_edge && s_r.en && (s_r.st != ST_CONV); // RQ14

  // Conversion length and completion
  assign conv_len = s_r.first ? `ADCC_CYC_FIRST : `ADCC_CYC_NORMAL; // RQ23
  assign cmpl = s_r.en && (s_r.st == ST_CONV) && tick && (s_r.cnt == 5'(conv_len - 5'h01));

  // Next state of registers, bus and engine
  always_comb begin
    s_nxt = s_r;
    s_nxt.sample = 1'b0;
    s_nxt.trig_q = trig_sig;
    // Capture write address and data in any order
    if (awvalid && awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = wdata[7:0];
      s_nxt.w_stb = wstrb[0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Perform write and answer
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      case (s_r.aw_addr)
        `ADCC_OFF_CHSEL, `ADCC_OFF_CSA, `ADCC_OFF_CSB,
        `ADCC_OFF_RESL, `ADCC_OFF_RESH: s_nxt.bresp = `ADCC_RESP_OKAY;
        default: s_nxt.bresp = `ADCC_RESP_SLVERR;
      endcase
    end
    if (wr_ch) begin
      s_nxt.ref_p = s_r.w_data[`ADCC_CH_REF_LSB +: 2];
      s_nxt.ladj = s_r.w_data[`ADCC_CH_LADJ];
      s_nxt.mux_p = s_r.w_data[`ADCC_CH_MUX_LSB +: 5]; // RQ22
    end
    if (wr_a) begin
      s_nxt.en = s_r.w_data[`ADCC_A_EN];
      s_nxt.ate = s_r.w_data[`ADCC_A_ATE]; // RQ11
      s_nxt.ie = s_r.w_data[`ADCC_A_IE];
      s_nxt.ps = s_r.w_data[`ADCC_A_PS_LSB +: 3];
      if (s_r.w_data[`ADCC_A_IF]) begin
        s_nxt.flag = 1'b0;
      end
    end
    if (wr_b) begin
      s_nxt.ts = s_r.w_data[`ADCC_B_TS_LSB +: 3]; // RQ11
    end
    // Read data and lock side effects
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `ADCC_RESP_OKAY;
      case (araddr[7:0])
        `ADCC_OFF_CHSEL: s_nxt.rdata = {s_r.ref_p, s_r.ladj, s_r.mux_p};
        `ADCC_OFF_CSA: s_nxt.rdata = {s_r.en, (s_r.st != ST_IDLE), s_r.ate,
                                      s_r.flag, s_r.ie, s_r.ps}; // RQ21
        `ADCC_OFF_CSB: s_nxt.rdata = {5'h00, s_r.ts};
        `ADCC_OFF_RESL: s_nxt.rdata = res_lo;
        `ADCC_OFF_RESH: s_nxt.rdata = res_hi;
        default: begin
          s_nxt.rdata = `ADCC_RST_BYTE;
          s_nxt.rresp = `ADCC_RESP_SLVERR;
        end
      endcase
    end
    if (rd_lo) begin
      s_nxt.lock = 1'b1; // RQ4
    end
    if (rd_hi) begin
      s_nxt.lock = 1'b0; // RQ6
    end
    // Selection follows pending only while enabled and not converting, or in the completion cycle
    if (s_r.en && (s_r.st != ST_CONV || cmpl)) begin
      s_nxt.ref_a = s_r.ref_p; // RQ1 RQ10
      s_nxt.mux_a = s_r.mux_p; // RQ1 RQ10
    end
    // Conversion engine
    if (!s_r.en) begin
      s_nxt.first = 1'b1;
      s_nxt.cnt = 5'h00;
      s_nxt.st = sc_wr ? ST_WAIT : ST_IDLE;
    end else begin
      case (s_r.st)
        ST_IDLE: begin
          if (trig_start) begin
            s_nxt.st = ST_CONV; // RQ12
            s_nxt.cnt = 5'h00;
            s_nxt.sample = 1'b1;
          end else if (sc_wr) begin
            s_nxt.st = ST_WAIT; // RQ8
          end
        end
        ST_WAIT: begin
          if (trig_start || tick) begin
            s_nxt.st = ST_CONV; // RQ26
            s_nxt.cnt = 5'h00;
            s_nxt.sample = 1'b1;
          end
        end
        ST_CONV: begin
          if (cmpl) begin
            s_nxt.flag = 1'b1; // RQ7 RQ24
            s_nxt.first = 1'b0;
            s_nxt.cnt = 5'h00;
            if (!s_r.lock) begin
              s_nxt.res = conv_data_i; // RQ5 RQ24
            end
            if (free_run) begin
              s_nxt.sample = 1'b1; // RQ17 RQ19
            end else begin
              s_nxt.st = ST_IDLE; // RQ9 RQ24
            end
          end else if (tick) begin
            s_nxt.cnt = 5'(s_r.cnt + 5'h01); // RQ23
          end
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.first <= 1'b1;
      s_r.res <= `ADCC_RST_RES;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign bresp = s_r.bresp;
  assign bvalid = s_r.bvalid;
  assign rdata = {24'h000000, s_r.rdata};
  assign rresp = s_r.rresp;
  assign rvalid = s_r.rvalid;
  assign analog_o.ref_sel = s_r.ref_a;
  assign analog_o.mux_sel = s_r.mux_a;
  assign analog_o.conv_on = s_r.en;
  assign analog_o.sample = s_r.sample;
  assign conv_irq_o = s_r.flag && s_r.ie;

  // Checks
  AST_START_BUSY: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    (sc_wr && s_r.en && s_r.st == ST_IDLE && !trig_start) |=> (s_r.st == ST_WAIT))
    else $error("start write did not begin a conversion");
  AST_LOCK_KEEP: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    (cmpl && s_r.lock) |=> $stable(s_r.res))
    else $error("result changed while locked");
  AST_DONE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    cmpl |=> s_r.flag)
    else $error("completion did not set done flag");
  AST_LOW_LOCK: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    rd_lo |=> s_r.lock && (s_r.rdata == $past(res_lo)))
    else $error("low byte read did not lock");
  AST_HIGH_UNLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    rd_hi |=> !s_r.lock)
    else $error("high byte read did not unlock");
  AST_OFF_IDLE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ25
    (!s_r.en && !sc_wr) |=> (s_r.st == ST_IDLE) && !tick)
    else $error("disabled converter not idle");
  AST_FREE_RUN: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
    (cmpl && free_run) |=> (s_r.st == ST_CONV) && s_r.sample)
    else $error("free running did not restart");
  AST_SINGLE_END: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
    (cmpl && !free_run) |=> (s_r.st == ST_IDLE) && s_r.flag)
    else $error("single conversion did not end cleanly");
  AST_MUX_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    (s_r.st == ST_CONV && !cmpl && s_r.en) |=> $stable(s_r.mux_a))
    else $error("channel changed mid conversion");
  AST_EDGE_IGNORE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (s_r.st == ST_CONV && trig_edge && !tick) |=> $stable(s_r.cnt))
    else $error("trigger edge disturbed a conversion");
  AST_TRIG_RESTART: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    trig_start |=> (s_r.st == ST_CONV) && s_r.sample && !tick)
    else $error("trigger edge did not restart prescaler and convert");
  AST_BUSY_READ: assert property (@(posedge aclk) disable iff (!aresetn) // RQ21
    (rd_go && araddr[7:0] == `ADCC_OFF_CSA && s_r.st == ST_CONV) |=> s_r.rdata[`ADCC_A_SC])
    else $error("start bit read low during conversion");
  AST_LEFT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (rd_hi && s_r.ladj) |=> (s_r.rdata == $past(s_r.res[9:2])))
    else $error("left aligned high byte wrong");
  AST_EN_PENDING: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    !s_r.en |=> $stable(s_r.mux_a) && $stable(s_r.ref_a))
    else $error("selection applied while disabled");
  AST_NO_QUEUE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (s_r.st == ST_CONV && !cmpl) |=> !s_r.sample)
    else $error("start issued inside a conversion");
  AST_LEVEL_NO_START: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    (s_r.st == ST_IDLE && trig_sig && s_r.trig_q && !sc_wr) |=> (s_r.st == ST_IDLE))
    else $error("steady trigger level started a conversion");
  AST_RES_STORE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ24
    (cmpl && !s_r.lock) |=> (s_r.res == $past(conv_data_i)))
    else $error("completion did not store the result");
endmodule

// ---- adcc_top_tb.sv ----
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top_tb;
  import adcc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} adcc_row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, conv_irq_o;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  adcc_analog_t analog_o;
  logic [9:0] conv_data_i;
  logic [`ADCC_TRIG_N-1:0] trig_flag_i;
  int n_fail, total_checks, cyc, n_starts, s, t;
  adcc_row_t rows [7] = '{'{`ADCC_OFF_CHSEL, 8'hE5, 8'hE5, 2'h0},
    '{`ADCC_OFF_CHSEL, 8'h00, 8'h00, 2'h0}, '{`ADCC_OFF_CSB, 8'h03, 8'h03, 2'h0},
    '{`ADCC_OFF_CSB, 8'h00, 8'h00, 2'h0}, '{`ADCC_OFF_RESL, 8'hFF, 8'h00, 2'h0},
    '{`ADCC_OFF_RESH, 8'hFF, 8'h00, 2'h0}, '{8'h20, 8'h55, 8'h00, 2'h2}};

  adcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .analog_o(analog_o), .conv_data_i(conv_data_i), .trig_flag_i(trig_flag_i),
    .conv_irq_o(conv_irq_o));

  // Clock generation
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Cycle count and conversion start count
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (analog_o.sample === 1'b1) n_starts <= n_starts + 1;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("mismatch at %0t: value %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t, w_t, done;
    done = 1'b0;
    wr_r = 2'hX;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      done = bvalid;
      if (done) wr_r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_t, done;
    done = 1'b0;
    rd_d = 'x;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      done = rvalid;
      if (done) begin
        rd_d = rdata;
        rd_r = rresp;
      end
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_d, {24'h000000, e});
  endtask

  // Poll the busy bit until it clears, returning elapsed cycles
  task automatic wait_done(output int el);
    int t0;
    t0 = cyc;
    rd(`ADCC_OFF_CSA);
    while (rd_d[`ADCC_A_SC] !== 1'b0) begin
      rd(`ADCC_OFF_CSA);
    end
    el = cyc - t0;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    $display("mismatch at %0t: watchdog timeout", $time);
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {n_fail, total_checks, cyc, n_starts} = '0;
    {awaddr, araddr, awvalid, wvalid, arvalid, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    conv_data_i = 10'h2A5;
    trig_flag_i = '0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(analog_o, 32'h0);
    chk(conv_irq_o, 1'b0);
    rchk(`ADCC_OFF_CSA, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(wr_r, rows[i].r);
      rd(rows[i].a);
      chk(rd_r, rows[i].r);
      if (rows[i].r == 2'h0) chk(rd_d, {24'h000000, rows[i].e});
    end
    // Selection stays pending until enabled
    wr(`ADCC_OFF_CHSEL, 8'h47);
    repeat (4) @(posedge aclk);
    chk(analog_o, 32'h0);
    wr(`ADCC_OFF_CSA, 8'h80);
    repeat (4) @(posedge aclk);
    chk(analog_o, {2'h1, 5'h07, 1'b1, 1'b0});
    // First conversion after enable
    s = n_starts;
    wr(`ADCC_OFF_CSA, 8'hC8);
    rd(`ADCC_OFF_CSA);
    chk(rd_d[`ADCC_A_SC], 1'b1);
    wait_done(t);
    chk_in(t, 46, 62);
    chk(n_starts - s, 1);
    rchk(`ADCC_OFF_CSA, 8'h98);
    chk(conv_irq_o, 1'b1);
    rchk(`ADCC_OFF_RESL, 8'hA5);
    rchk(`ADCC_OFF_RESH, 8'h02);
    wr(`ADCC_OFF_CHSEL, 8'h27);
    rchk(`ADCC_OFF_RESL, 8'h40);
    rchk(`ADCC_OFF_RESH, 8'hA9);
    wr(`ADCC_OFF_CHSEL, 8'h07);
    // Completion while locked loses the result but flags it
    wr(`ADCC_OFF_CSA, 8'h98);
    chk(conv_irq_o, 1'b0);
    conv_data_i <= 10'h155;
    rd(`ADCC_OFF_RESL);
    wr(`ADCC_OFF_CSA, 8'hC8);
    wait_done(t);
    chk_in(t, 22, 36);
    chk(conv_irq_o, 1'b1);
    rchk(`ADCC_OFF_RESH, 8'h02);
    rchk(`ADCC_OFF_RESL, 8'hA5);
    rchk(`ADCC_OFF_RESH, 8'h02);
    wr(`ADCC_OFF_CSA, 8'hD8);
    wait_done(t);
    rchk(`ADCC_OFF_RESL, 8'h55);
    rchk(`ADCC_OFF_RESH, 8'h01);
    // Channel change mid conversion
    wr(`ADCC_OFF_CSA, 8'hC0);
    repeat (3) @(posedge aclk);
    wr(`ADCC_OFF_CHSEL, 8'h03);
    chk(analog_o.mux_sel, 5'h07);
    wait_done(t);
    repeat (2) @(posedge aclk);
    chk(analog_o.mux_sel, 5'h03);
    // Edge triggering from source one
    wr(`ADCC_OFF_CSB, 8'h01);
    wr(`ADCC_OFF_CSA, 8'hA0);
    s = n_starts;
    trig_flag_i <= 7'h02;
    repeat (40) @(posedge aclk);
    chk(n_starts - s, 0);
    trig_flag_i <= 7'h03;
    repeat (8) @(posedge aclk);
    rd(`ADCC_OFF_CSA);
    chk(rd_d[`ADCC_A_SC], 1'b1);
    trig_flag_i <= 7'h02;
    repeat (2) @(posedge aclk);
    trig_flag_i <= 7'h03;
    wait_done(t);
    repeat (60) @(posedge aclk);
    chk(n_starts - s, 1);
    s = n_starts;
    wr(`ADCC_OFF_CSA, 8'hE0);
    wait_done(t);
    repeat (40) @(posedge aclk);
    chk(n_starts - s, 1);
    // Free running on the done flag, flag never cleared
    trig_flag_i <= 7'h00;
    wr(`ADCC_OFF_CSB, 8'h00);
    s = n_starts;
    wr(`ADCC_OFF_CSA, 8'hE0);
    repeat (120) @(posedge aclk);
    chk_in(n_starts - s, 4, 6);
    rd(`ADCC_OFF_CSA);
    chk(rd_d[`ADCC_A_SC], 1'b1);
    wr(`ADCC_OFF_CSA, 8'h80);
    wait_done(t);
    rchk(`ADCC_OFF_CSA, 8'h90);
    s = n_starts;
    repeat (40) @(posedge aclk);
    chk(n_starts - s, 0);
    // Reset in mid conversion returns every register to idle
    wr(`ADCC_OFF_CSA, 8'hC0);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(analog_o, 32'h0);
    rchk(`ADCC_OFF_CSA, 8'h00);
    rchk(`ADCC_OFF_RESL, 8'h00);
    end_of_test();
  end
endmodule
